// ### adc_serial_output_port_tb.sv
// testbench: converter port and host controller joined over the serial link
`include "asp_defs.svh"
`default_nettype none
module adc_serial_output_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys;
	logic resetn;
	logic conv_start;
	logic polarity_select;
	logic signed [18:0] sample_half;
	logic conv_busy;
	logic [15:0] result_code;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] rdv;
	int num_errors;
	int total_checks;
	int ready_hi;
	logic polv [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	logic signed [18:0] xv [10] = '{19'sh1FFFF, 19'sh0FFFD, 19'sh70001, 19'sh40000,
		19'sh7FFFE, 19'sh00001, 19'sh7FFF0, 19'sh0FFFF, 19'sh1FFFD, 19'sh3FFF0};

	// ----------------------------------------
	// design
	// ----------------------------------------
	asp_if asp_if_i ();
	asp_device asp_device_i (.clk_sys(clk_sys), .resetn(resetn), .link(asp_if_i.dev),
		.conv_start(conv_start), .polarity_select(polarity_select),
		.sample_half(sample_half), .conv_busy(conv_busy), .result_code(result_code));
	asp_host asp_host_i (.clk_sys(clk_sys), .resetn(resetn), .link(asp_if_i.host), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	asp_link_props asp_link_props_i (.clk_sys(clk_sys), .resetn(resetn),
		.port_sel_n(asp_if_i.port_sel_n), .port_mode_select(asp_if_i.port_mode_select),
		.shift_clk_dev(asp_if_i.shift_clk_dev), .shift_clk_dev_oe(asp_if_i.shift_clk_dev_oe),
		.shift_clk(asp_if_i.shift_clk), .serial_data_out_drv(asp_if_i.serial_data_out_drv),
		.serial_data_out_oe(asp_if_i.serial_data_out_oe), .ready_n(asp_if_i.ready_n));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic complete_run();
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_up_unless(input logic ok);
		if (ok !== 1'b1) begin
			num_errors++;
			complete_run();
		end
	endtask : give_up_unless

	task automatic wait_hready();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		give_up_unless(hreadyout);
	endtask : wait_hready

	// caller is always just past a rising edge, so the address phase starts at once
	task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		wait_hready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_hready();
		rdv = hrdata;
	endtask : ahb

	// floor of half the input plus one half-lsb, then clamped to the coding's range
	function automatic logic [15:0] exp_code(input logic pol, input logic signed [18:0] x);
		logic signed [19:0] t;
		t = x;
		t = (t + 20'sh00001) >>> 1;
		if (pol)
			t = (t > 20'sh07FFF) ? 20'sh07FFF : ((t < 20'shF8000) ? 20'shF8000 : t);
		else
			t = (t > 20'sh0FFFF) ? 20'sh0FFFF : ((t < 20'sh00000) ? 20'sh00000 : t);
		return t[15:0];
	endfunction : exp_code

	// counts cycles with ready high while the conversion runs
	task automatic convert(input logic pol, input logic signed [18:0] x);
		int n;
		polarity_select <= pol;
		sample_half <= x;
		repeat (4) @(posedge clk_sys);
		conv_start <= 1'b1;
		@(posedge clk_sys);
		conv_start <= 1'b0;
		n = 0;
		ready_hi = 0;
		do begin
			@(posedge clk_sys);
			n++;
			ready_hi += (asp_if_i.ready_n === 1'b1 && conv_busy === 1'b1) ? 1 : 0;
		end while (conv_busy !== 1'b0 && n < 200);
		give_up_unless(!conv_busy);
		check("result_code", {16'h0000, exp_code(pol, x)}, {16'h0000, result_code});
	endtask : convert

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_reset_values();
		ahb(1'b0, `ASP_REG_CTRL, 32'h0);
		check("ctrl", 32'h0, rdv);
		ahb(1'b0, `ASP_REG_STATUS, 32'h0);
		check("status", 32'h0, rdv);
		ahb(1'b1, 32'h0000000C, 32'hFFFFFFFF);
		ahb(1'b0, 32'h0000000C, 32'h0);
		check("unmapped", 32'h0, rdv);
		check("hresp", 32'h0, {31'h0, hresp});
		ahb(1'b1, 32'h00000100, 32'hFFFFFFFF);
		ahb(1'b0, `ASP_REG_CTRL, 32'h0);
		check("ctrl_after", 32'h0, rdv);
		check("idle_oe", 32'h0, {31'h0, asp_if_i.serial_data_out_oe});
	endtask : s_reset_values

	task automatic s_words(input logic [31:0] ctrl, input int count);
		int n;
		ahb(1'b1, `ASP_REG_CTRL, ctrl);
		repeat (8) @(posedge clk_sys);
		for (int i = 0; i < count; i++) begin
			convert(polv[i], xv[i]);
			n = 0;
			do begin
				ahb(1'b0, `ASP_REG_STATUS, 32'h0);
				n++;
			end while (rdv[`ASP_ST_VALID] !== 1'b1 && n < 150);
			give_up_unless(rdv[`ASP_ST_VALID]);
			ahb(1'b0, `ASP_REG_DATA, 32'h0);
			check("data_word", {16'h0000, exp_code(polv[i], xv[i])}, rdv);
		end
	endtask : s_words

	// a word that finishes while the host still shifts the last one is dropped
	task automatic s_busy_read();
		int n;
		ahb(1'b1, `ASP_REG_CTRL, 32'h1);
		repeat (8) @(posedge clk_sys);
		convert(polv[0], xv[0]);
		convert(polv[5], xv[5]);
		n = 0;
		do begin
			ahb(1'b0, `ASP_REG_STATUS, 32'h0);
			n++;
		end while (rdv[`ASP_ST_VALID] !== 1'b1 && n < 150);
		give_up_unless(rdv[`ASP_ST_VALID]);
		ahb(1'b0, `ASP_REG_DATA, 32'h0);
		check("kept_word", {16'h0000, exp_code(polv[0], xv[0])}, rdv);
		ahb(1'b0, `ASP_REG_STATUS, 32'h0);
		check("after_drop", 32'h0, rdv);
		check("drop_ready", 32'h1, {31'h0, asp_if_i.ready_n});
	endtask : s_busy_read

	task automatic s_overwrite();
		ahb(1'b1, `ASP_REG_CTRL, 32'h4);
		repeat (8) @(posedge clk_sys);
		convert(1'b1, 19'sh00100);
		convert(1'b1, 19'sh70001);
		check("early_ready", 32'h2, ready_hi);
		check("ready_low", 32'h0, {31'h0, asp_if_i.ready_n});
	endtask : s_overwrite

	task automatic s_self_float();
		int bad;
		ahb(1'b1, `ASP_REG_CTRL, 32'h2);
		repeat (8) @(posedge clk_sys);
		convert(1'b0, 19'sh00010);
		bad = 0;
		repeat (40) begin
			@(posedge clk_sys);
			bad += (asp_if_i.serial_data_out_oe !== 1'b0 || asp_if_i.shift_clk_dev_oe !== 1'b0);
		end
		check("float_cycles", 32'h0, bad);
		check("held_ready", 32'h0, {31'h0, asp_if_i.ready_n});
	endtask : s_self_float

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		resetn = 1'b0;
		conv_start = 1'b0;
		polarity_select = 1'b0;
		sample_half = 19'sh00000;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		num_errors = 0;
		total_checks = 0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		s_reset_values();
		s_words(32'h1, 10);
		s_words(32'h3, 10);
		s_busy_read();
		s_overwrite();
		s_self_float();
		// a second reset must drop the held word and leave the port usable
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check("ready_after_reset", 32'h1, {31'h0, asp_if_i.ready_n});
		s_words(32'h1, 2);
		complete_run();
	end
endmodule : adc_serial_output_port_tb
`default_nettype wire

// ### asp_defs.svh
// constants of the converter serial output port and its host controller
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// timing
`define ASP_CLK_PERIOD_NS 10
`define ASP_SCLK_PERIOD_NS 80
`define ASP_HALF_CYC (`ASP_SCLK_PERIOD_NS / (2 * `ASP_CLK_PERIOD_NS))
`define ASP_CONV_CYCLES 7'h50
`define ASP_READY_EARLY 7'h02
`define ASP_SETUP_CYC 3'h4

// word framing: sixteen data bits, one extra rising edge to capture the last
`define ASP_WORD_BITS 5'h10
`define ASP_LAST_EDGE 5'h11

// coding limits, input in half-lsb units
`define ASP_BP_TOP 19'sh07FFF
`define ASP_BP_BOT 19'sh78000
`define ASP_UP_TOP 19'sh0FFFF
`define ASP_UP_BOT 19'sh00000
`define ASP_BP_MAX 16'h7FFF
`define ASP_BP_MIN 16'h8000
`define ASP_UP_MAX 16'hFFFF
`define ASP_UP_MIN 16'h0000

// host registers
`define ASP_REG_CTRL 8'h00
`define ASP_REG_STATUS 8'h04
`define ASP_REG_DATA 8'h08
`define ASP_CTRL_ENABLE 0
`define ASP_CTRL_SELF 1
`define ASP_CTRL_HOLD_SEL 2
`define ASP_ST_VALID 0
`define ASP_ST_OVERRUN 1
`define ASP_ST_BUSY 2
`define ASP_ST_READY 3

`endif

// ### asp_device.sv
// converter end: result coding, conversion timing and serial output port
`include "asp_defs.svh"
`default_nettype none
module asp_device (
	input wire logic clk_sys,
	input wire logic resetn,
	asp_if.dev link,
	input wire logic conv_start,
	input wire logic polarity_select,
	input wire logic signed [18:0] sample_half,
	output logic conv_busy,
	output logic [15:0] result_code
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sel_sync;
		logic [1:0] clk_sync;
		logic [1:0] mode_sync;
		logic [1:0] pol_sync;
		logic clk_prev;
		logic busy;
		logic [6:0] conv_cnt;
		asp_pkg::asp_dev_state_t state;
		logic self_mode;
		logic [15:0] shreg;
		logic [4:0] edges;
		logic [2:0] div;
		logic shift_clk;
		logic shift_clk_oe;
		logic sdata;
		logic sdata_oe;
		logic ready_n;
		logic [15:0] result;
	} asp_dev_st_t;

	asp_dev_st_t s;
	asp_dev_st_t n;

	// ------------------------------------------------------------
	// result coding
	// ------------------------------------------------------------
	// input is in half-lsb units; adding one half before halving puts
	// the first step half an lsb above the bottom of the span and the
	// last step one and a half lsbs below its top
	function automatic logic [15:0] asp_code(
		input logic signed [18:0] x,
		input logic bipolar
	);
		logic signed [18:0] t;
		logic [15:0] c;
		t = (x + 19'sh00001) >>> 1;
		c = t[15:0];
		if (bipolar) begin
			if (t > `ASP_BP_TOP) begin
				c = `ASP_BP_MAX;
			end else if (t < `ASP_BP_BOT) begin
				c = `ASP_BP_MIN;
			end
		end else begin
			if (t > `ASP_UP_TOP) begin
				c = `ASP_UP_MAX;
			end else if (t < `ASP_UP_BOT) begin
				c = `ASP_UP_MIN;
			end
		end
		return c;
	endfunction : asp_code

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic sel_low;
	logic clk_rise;
	logic done;
	logic [15:0] word;

	always_comb begin
		n = s;
		sel_low = ~s.sel_sync[1];
		clk_rise = s.clk_sync[1] & ~s.clk_prev;
		done = s.busy && (s.conv_cnt == `ASP_CONV_CYCLES - 7'h01);
		word = asp_code(sample_half, s.pol_sync[1]);

		n.sel_sync = {s.sel_sync[0], link.port_sel_n};
		n.clk_sync = {s.clk_sync[0], link.shift_clk};
		n.mode_sync = {s.mode_sync[0], link.port_mode_select};
		n.pol_sync = {s.pol_sync[0], polarity_select};
		n.clk_prev = s.clk_sync[1];

		// conversion timer; a start in the finishing cycle chains on
		if (s.busy) begin
			n.conv_cnt = s.conv_cnt + 7'h01;
		end
		if (done) begin
			n.busy = 1'b0;
			n.result = word;
		end
		if (conv_start && (!s.busy || done)) begin
			n.busy = 1'b1;
			n.conv_cnt = 7'h00;
		end

		case (s.state)
			asp_pkg::ASP_D_IDLE: begin
				n.sdata = 1'b0;
			end
			asp_pkg::ASP_D_LOADED: begin
				// unread word with select low: warn the host that it is about to go
				if (sel_low && s.busy &&
					(s.conv_cnt == `ASP_CONV_CYCLES - 7'h01 - `ASP_READY_EARLY)) begin
					n.ready_n = 1'b1;
				end
				if (!s.self_mode && clk_rise && sel_low) begin
					n.state = asp_pkg::ASP_D_SHIFT;
					n.sdata = s.shreg[15];
					n.shreg = {s.shreg[14:0], 1'b0};
					n.edges = 5'h01;
				end
			end
			asp_pkg::ASP_D_SHIFT: begin
				if (s.self_mode) begin
					if (s.div == 3'(`ASP_HALF_CYC - 1)) begin
						n.div = 3'h0;
						n.shift_clk = ~s.shift_clk;
						if (!s.shift_clk) begin
							n.edges = s.edges + 5'h01;
							if (s.edges < `ASP_WORD_BITS) begin
								n.sdata = s.shreg[15];
								n.shreg = {s.shreg[14:0], 1'b0};
							end else begin
								n.sdata = 1'b0;
							end
						end else if (s.edges == `ASP_LAST_EDGE) begin
							// released half a period after the last capture edge
							n.ready_n = 1'b1;
							n.state = asp_pkg::ASP_D_IDLE;
						end
					end else begin
						n.div = s.div + 3'h1;
					end
				end else if (clk_rise && sel_low) begin
					n.edges = s.edges + 5'h01;
					if (s.edges < `ASP_WORD_BITS) begin
						n.sdata = s.shreg[15];
						n.shreg = {s.shreg[14:0], 1'b0};
					end else begin
						// port empty: no new data until the next load
						n.sdata = 1'b0;
						n.ready_n = 1'b1;
						n.state = asp_pkg::ASP_D_IDLE;
					end
				end
			end
			default: begin
				n.state = asp_pkg::ASP_D_IDLE;
			end
		endcase

		// a finished result never disturbs a read in progress; the new
		// word is dropped, which a slow host sees as a missing sample
		if (done && (s.state != asp_pkg::ASP_D_SHIFT)) begin
			n.shreg = word;
			n.ready_n = 1'b0;
			n.edges = 5'h00;
			n.div = 3'h0;
			n.shift_clk = 1'b0;
			n.sdata = 1'b0;
			n.self_mode = s.mode_sync[1];
			if (s.mode_sync[1] && sel_low) begin
				n.state = asp_pkg::ASP_D_SHIFT;
			end else begin
				n.state = asp_pkg::ASP_D_LOADED;
			end
		end

		n.sdata_oe = sel_low;
		n.shift_clk_oe = s.mode_sync[1] & sel_low;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.sel_sync <= 2'h3;
			s.ready_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign link.shift_clk_dev = s.shift_clk;
	assign link.shift_clk_dev_oe = s.shift_clk_oe;
	assign link.serial_data_out_drv = s.sdata;
	assign link.serial_data_out_oe = s.sdata_oe;
	assign link.ready_n = s.ready_n;
	assign conv_busy = s.busy;
	assign result_code = s.result;

endmodule : asp_device
`default_nettype wire

// ### asp_host.sv
// host end: reads conversion words off the link, AHB-Lite register slave
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`include "asp_defs.svh"
`default_nettype none
module asp_host (
	input wire logic clk_sys,
	input wire logic resetn,
	asp_if.host link,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] rdy_sync;
		logic [1:0] clk_sync;
		logic [1:0] sd_sync;
		logic sd_prev;
		logic clk_prev;
		logic rdy_prev;
		asp_pkg::asp_host_state_t state;
		logic mode_self;
		logic sel_n;
		logic shift_clk;
		logic shift_clk_oe;
		logic [2:0] div;
		logic [4:0] edges;
		logic [15:0] shreg;
		logic [2:0] ctrl;
		logic valid;
		logic overrun;
		logic [15:0] data;
		logic ph_valid;
		logic ph_write;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
	} asp_host_st_t;

	asp_host_st_t s;
	asp_host_st_t n;

	logic take;
	logic rdy_fall;
	logic clk_rise;
	logic idle_sel_n;
	logic finish;
	logic [15:0] cap;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n = s;
		finish = 1'b0;
		cap = {s.shreg[14:0], s.sd_prev};
		n.rdy_sync = {s.rdy_sync[0], link.ready_n};
		n.clk_sync = {s.clk_sync[0], link.shift_clk};
		n.sd_sync = {s.sd_sync[0], link.serial_data_out};
		// value just before the edge: the device changes data with the edge
		n.sd_prev = s.sd_sync[1];
		n.clk_prev = s.clk_sync[1];
		n.rdy_prev = s.rdy_sync[1];
		rdy_fall = s.rdy_prev & ~s.rdy_sync[1];
		clk_rise = s.clk_sync[1] & ~s.clk_prev;
		// hold keeps select low even with reads off, so replacing an unread word gives the early ready pulse
		idle_sel_n = ~((s.ctrl[`ASP_CTRL_ENABLE] & s.mode_self) |
			s.ctrl[`ASP_CTRL_HOLD_SEL]);

		// bus slave, zero wait states
		take = hsel & htrans[1] & hready;
		if (s.ph_valid && s.ph_write) begin
			if (s.ph_addr == `ASP_REG_CTRL) begin
				n.ctrl = hwdata[2:0];
			end else if (s.ph_addr == `ASP_REG_STATUS && hwdata[`ASP_ST_OVERRUN]) begin
				n.overrun = 1'b0;
			end
		end
		// writes above the register page are dropped, as reads there return zero
		n.ph_valid = take & (haddr[31:8] == 24'h00_0000);
		n.ph_write = hwrite;
		n.ph_addr = haddr[7:0];
		n.rdata = 32'h0000_0000;
		if (take && !hwrite && haddr[31:8] == 24'h00_0000) begin
			case (haddr[7:0])
				`ASP_REG_CTRL: n.rdata = {29'h0000_0000, s.ctrl};
				`ASP_REG_STATUS: n.rdata = {28'h000_0000, ~s.rdy_sync[1],
					(s.state != asp_pkg::ASP_H_IDLE), s.overrun, s.valid};
				`ASP_REG_DATA: begin
					n.rdata = {16'h0000, s.data};
					n.valid = 1'b0;
				end
				default: n.rdata = 32'h0000_0000;
			endcase
		end

		case (s.state)
			asp_pkg::ASP_H_IDLE: begin
				// mode changes only between words, with the port quiet
				n.mode_self = s.ctrl[`ASP_CTRL_SELF];
				n.shift_clk_oe = ~s.ctrl[`ASP_CTRL_SELF];
				n.sel_n = idle_sel_n;
				n.edges = 5'h00;
				n.div = 3'h0;
				n.shift_clk = 1'b0;
				if (s.ctrl[`ASP_CTRL_ENABLE] && rdy_fall) begin
					if (s.mode_self) begin
						if (!s.sel_n) begin
							n.state = asp_pkg::ASP_H_SELF;
						end
					end else begin
						n.sel_n = 1'b0;
						n.state = asp_pkg::ASP_H_SETUP;
					end
				end
			end
			asp_pkg::ASP_H_SETUP: begin
				n.div = s.div + 3'h1;
				if (s.div == `ASP_SETUP_CYC - 3'h1) begin
					n.div = 3'h0;
					n.state = asp_pkg::ASP_H_CLK;
				end
			end
			asp_pkg::ASP_H_CLK: begin
				n.div = s.div + 3'h1;
				if (s.div == 3'(`ASP_HALF_CYC - 1)) begin
					n.div = 3'h0;
					n.shift_clk = ~s.shift_clk;
					if (!s.shift_clk) begin
						n.edges = s.edges + 5'h01;
						if (s.edges != 5'h00) begin
							n.shreg = cap;
						end
					end else if (s.edges == `ASP_LAST_EDGE) begin
						finish = 1'b1;
					end
				end
			end
			asp_pkg::ASP_H_SELF: begin
				if (clk_rise) begin
					n.edges = s.edges + 5'h01;
					if (s.edges != 5'h00) begin
						n.shreg = cap;
					end
					if (s.edges == `ASP_WORD_BITS) begin
						finish = 1'b1;
					end
				end else if (s.rdy_sync[1]) begin
					n.state = asp_pkg::ASP_H_IDLE;
				end
			end
			default: begin
				n.state = asp_pkg::ASP_H_IDLE;
			end
		endcase

		// a new word beats a data read in the same cycle
		if (finish) begin
			n.data = (s.state == asp_pkg::ASP_H_SELF) ? cap : s.shreg;
			n.overrun = n.overrun | (s.valid & n.valid);
			n.valid = 1'b1;
			n.sel_n = idle_sel_n;
			n.state = asp_pkg::ASP_H_IDLE;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.rdy_sync <= 2'h3;
			s.rdy_prev <= 1'b1;
			s.sel_n <= 1'b1;
			s.shift_clk_oe <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign link.port_sel_n = s.sel_n;
	assign link.port_mode_select = s.mode_self;
	assign link.shift_clk_host = s.shift_clk;
	assign link.shift_clk_host_oe = s.shift_clk_oe;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;

endmodule : asp_host
`default_nettype wire

// ### asp_if.sv
// serial link between converter port and host controller
`default_nettype none
interface asp_if;
	logic port_sel_n;
	logic port_mode_select;
	logic shift_clk_dev;
	logic shift_clk_dev_oe;
	logic shift_clk_host;
	logic shift_clk_host_oe;
	logic serial_data_out_drv;
	logic serial_data_out_oe;
	logic ready_n;
	logic shift_clk;
	logic serial_data_out;

	// floating lines settle low, as with board pull-downs
	assign shift_clk = shift_clk_dev_oe ? shift_clk_dev :
		(shift_clk_host_oe ? shift_clk_host : 1'b0);
	assign serial_data_out = serial_data_out_oe ? serial_data_out_drv : 1'b0;

	modport dev (
		input port_sel_n,
		input port_mode_select,
		input shift_clk,
		output shift_clk_dev,
		output shift_clk_dev_oe,
		output serial_data_out_drv,
		output serial_data_out_oe,
		output ready_n
	);

	modport host (
		input shift_clk,
		input serial_data_out,
		input ready_n,
		output port_sel_n,
		output port_mode_select,
		output shift_clk_host,
		output shift_clk_host_oe
	);
endinterface : asp_if
`default_nettype wire

// ### asp_link_props.sv
// concurrent checks on the serial link between converter port and host
`include "asp_defs.svh"
`default_nettype none
module asp_link_props (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic port_sel_n,
	input wire logic port_mode_select,
	input wire logic shift_clk_dev,
	input wire logic shift_clk_dev_oe,
	input wire logic shift_clk,
	input wire logic serial_data_out_drv,
	input wire logic serial_data_out_oe,
	input wire logic ready_n
);
	// ----------------------------------------
	// helper: link clock rises since ready fell
	// ----------------------------------------
	logic clk_q;
	logic [4:0] edge_cnt;

	// saturates so a runaway clock cannot wrap back into a legal count
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			clk_q <= 1'b0;
			edge_cnt <= 5'h00;
		end else begin
			clk_q <= shift_clk;
			if (ready_n)
				edge_cnt <= 5'h00;
			else if (shift_clk && !clk_q && edge_cnt != 5'h1F)
				edge_cnt <= edge_cnt + 5'h01;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	// five cycles leave room for the select synchroniser and the output flop
	chk_sel_data_float: assert property (port_sel_n [*5] |-> !serial_data_out_oe)
		else $error("data driven while select high");
	chk_sel_clk_float: assert property ((port_sel_n && port_mode_select) [*5] |-> !shift_clk_dev_oe)
		else $error("clock driven while select high");
	chk_ext_no_clk: assert property ((!port_mode_select) [*5] |-> !shift_clk_dev_oe)
		else $error("device drives clock in external mode");
	chk_self_clk_period: assert property ($rose(shift_clk_dev) |-> shift_clk_dev [*4] ##1 !shift_clk_dev)
		else $error("self clock half period wrong");
	chk_self_start: assert property (($fell(ready_n) && port_mode_select && !port_sel_n
		&& !$past(port_sel_n, 4)) |-> ##[3:6] $rose(shift_clk_dev))
		else $error("self clocked shift did not start");
	chk_word_length: assert property ($rose(ready_n) |-> (edge_cnt == 5'h00 || edge_cnt == `ASP_LAST_EDGE))
		else $error("ready rose after wrong edge count");
	chk_word_stop: assert property (!ready_n |-> edge_cnt <= `ASP_LAST_EDGE)
		else $error("clock edges beyond one word");
	chk_early_ready: assert property (($rose(ready_n) && edge_cnt == 5'h00) |-> ##2 $fell(ready_n))
		else $error("early ready pulse not two cycles");
	chk_data_hold: assert property ((((!port_mode_select && $rose(shift_clk))
		|| (port_mode_select && $fell(shift_clk))) && !ready_n) |-> $stable(serial_data_out_drv))
		else $error("data moved at capture edge");

	cov_self_word: cover property ($fell(ready_n) && port_mode_select);
	cov_ext_word: cover property ($fell(ready_n) && !port_mode_select);
	cov_overwrite: cover property ($rose(ready_n) && edge_cnt == 5'h00);
endmodule : asp_link_props
`default_nettype wire

// ### asp_pkg.sv
// types of the converter serial output port
`default_nettype none
package asp_pkg;

	typedef enum logic [1:0] {
		ASP_D_IDLE,
		ASP_D_LOADED,
		ASP_D_SHIFT
	} asp_dev_state_t;

	typedef enum logic [1:0] {
		ASP_H_IDLE,
		ASP_H_SETUP,
		ASP_H_CLK,
		ASP_H_SELF
	} asp_host_state_t;

endpackage : asp_pkg
`default_nettype wire
